// ===== rtl/ppt_pkg.sv
// Package: register map, field layout, reset values and phase type of the parallel port
package ppt_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_TARGET = 8'h04;
    localparam logic [7:0] OFS_PIN_EN = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_OUT_BUF = 8'h10;
    localparam logic [7:0] OFS_IN_BUF = 8'h14;
    localparam logic [7:0] OFS_MWRITE = 8'h18;
    localparam logic [7:0] OFS_MREAD = 8'h1C;
    // ------------------------------------------------------------
    // Mode register fields
    // ------------------------------------------------------------
    localparam int HOLD_LSB = 0;
    localparam int WIDTH_LSB = 2;
    localparam int SETUP_LSB = 6;
    localparam int PMODE_LSB = 8;
    localparam int STEP_LSB = 11;
    localparam int BUSY_BIT = 15;
    localparam int MUX_LSB = 16;
    // ------------------------------------------------------------
    // Target, pin enable and status fields
    // ------------------------------------------------------------
    localparam int LOC_W = 11;
    localparam int CS1_BIT = 14;
    localparam int STEP_LO = 2;
    localparam int ALL_FULL_BIT = 15;
    localparam int OVF_BIT = 14;
    localparam int IN_FULL_LSB = 8;
    localparam int ALL_EMPTY_BIT = 7;
    localparam int UNF_BIT = 6;
    localparam int OUT_EMPTY_LSB = 0;
    // ------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] STEP_INC = 2'h1;
    localparam logic [1:0] STEP_DEC = 2'h2;
    localparam logic [1:0] MUX_SEPARATE = 2'h0;
    localparam logic [3:0] WIDTH_MIN = 4'h0;
    localparam logic [1:0] RST_WAIT = 2'h0;
    localparam logic [3:0] RST_IN_FULL = 4'h0;
    localparam logic [3:0] RST_OUT_EMPTY = 4'hF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int TPB_NS = 10;
    localparam int CLK_NS = 10;
    localparam int TPB_CYCLES = (TPB_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [2:0] {
        PPT_IDLE,
        PPT_ADDR,
        PPT_SETUP,
        PPT_STROBE,
        PPT_HOLD
    } ppt_phase_t;
endpackage

// ===== rtl/ppt_strobe_seq.sv
// Strobe sequencer: address, setup, strobe and hold phases of one master cycle
module ppt_strobe_seq (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic i_write,
    input wire logic i_mux_on,
    input wire logic [1:0] i_setup,
    input wire logic [3:0] i_width,
    input wire logic [1:0] i_hold,
    output ppt_pkg::ppt_phase_t o_phase,
    output logic o_strobe_last,
    output logic o_done
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        ppt_pkg::ppt_phase_t phase;
        logic [3:0] cnt;
        logic wr;
        logic [1:0] setup;
        logic [3:0] width;
        logic [1:0] hold;
    } ppt_seq_t;

    ppt_seq_t st;
    ppt_seq_t next_st;

    if (ppt_pkg::TPB_CYCLES != 1) begin
        $error("Bus cycle must equal one clock");
    end

    // Setup in cycles minus one, hold in cycles; short strobe forces setup 1 and hold 1 or 0
    function automatic logic [3:0] setup_len(input logic [1:0] code, input logic [3:0] w);
        setup_len = (w == ppt_pkg::WIDTH_MIN) ? 4'h0 : {2'h0, code};
    endfunction

    function automatic logic [2:0] hold_len(input logic [1:0] code, input logic [3:0] w,
                                            input logic wr);
        if (w == ppt_pkg::WIDTH_MIN) begin
            hold_len = wr ? 3'h1 : 3'h0;
        end else begin
            hold_len = wr ? {1'b0, code} + 3'h1 : {1'b0, code};
        end
    endfunction

    assign o_phase = st.phase;
    assign o_strobe_last = (st.phase == ppt_pkg::PPT_STROBE) && (st.cnt == 4'h0);
    assign o_done = (st.phase == ppt_pkg::PPT_HOLD) && (st.cnt == 4'h1)
        || o_strobe_last && (hold_len(st.hold, st.width, st.wr) == 3'h0);

    always_comb begin
        next_st = st;
        unique case (st.phase)
            ppt_pkg::PPT_IDLE: begin
                if (i_start) begin
                    next_st.wr = i_write;
                    next_st.setup = i_setup;
                    next_st.width = i_width;
                    next_st.hold = i_hold;
                    next_st.cnt = setup_len(i_setup, i_width);
                    next_st.phase = i_mux_on ? ppt_pkg::PPT_ADDR : ppt_pkg::PPT_SETUP;
                end
            end
            ppt_pkg::PPT_ADDR: begin
                if (st.cnt == 4'h0) begin
                    next_st.cnt = setup_len(st.setup, st.width);
                    next_st.phase = ppt_pkg::PPT_SETUP;
                end else begin
                    next_st.cnt = st.cnt - 4'h1;
                end
            end
            ppt_pkg::PPT_SETUP: begin
                if (st.cnt == 4'h0) begin
                    next_st.cnt = st.width;
                    next_st.phase = ppt_pkg::PPT_STROBE;
                end else begin
                    next_st.cnt = st.cnt - 4'h1;
                end
            end
            ppt_pkg::PPT_STROBE: begin
                if (st.cnt == 4'h0) begin
                    next_st.cnt = {1'b0, hold_len(st.hold, st.width, st.wr)};
                    next_st.phase = (hold_len(st.hold, st.width, st.wr) == 3'h0)
                        ? ppt_pkg::PPT_IDLE : ppt_pkg::PPT_HOLD;
                end else begin
                    next_st.cnt = st.cnt - 4'h1;
                end
            end
            ppt_pkg::PPT_HOLD: begin
                next_st.cnt = st.cnt - 4'h1;
                if (st.cnt == 4'h1) begin
                    next_st.phase = ppt_pkg::PPT_IDLE;
                end
            end
            default: next_st.phase = ppt_pkg::PPT_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// ===== rtl/ppt_port.sv
// Parallel port registers, pin functions, slave buffers and master cycles
// ------------------------------------------------------------
// Top level
// ------------------------------------------------------------
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
module ppt_port #(
    parameter int NUM_BUF = 4
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [7:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    input wire logic i_host_wr,
    input wire logic i_host_rd,
    input wire logic [1:0] i_host_sel,
    input wire logic [7:0] i_host_wdata,
    output logic [7:0] o_host_rdata,
    input wire logic [7:0] i_port_data_pins,
    output logic [7:0] o_port_data_pins,
    output logic o_port_data_pins_oe,
    output logic [10:0] o_location_pins,
    output logic [10:0] o_location_pin_function_enable,
    output logic o_chip_select_one_pin,
    output logic o_select_pin_function_enable,
    output logic o_read_strobe,
    output logic o_write_strobe
);
    if (NUM_BUF != 4) begin
        $error("Status layout serves exactly four buffers");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [7:0] aw_addr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [1:0] strobe_hold_wait;
        logic [3:0] strobe_width_wait;
        logic [1:0] strobe_setup_wait;
        logic [1:0] port_mode;
        logic [1:0] step_mode;
        logic [1:0] location_multiplex_select;
        logic [10:0] location;
        logic chip_select_one_active;
        logic [10:0] location_pin_function_enable;
        logic select_pin_function_enable;
        logic [NUM_BUF-1:0][7:0] in_buf;
        logic [NUM_BUF-1:0] input_buffer_n_full;
        logic input_overflow;
        logic [NUM_BUF-1:0][7:0] out_buf;
        logic [NUM_BUF-1:0] output_buffer_n_empty;
        logic output_underflow;
        logic [7:0] host_rdata;
        logic cyc_write;
        logic [7:0] mwdata;
        logic [7:0] mrdata;
    } ppt_state_t;

    ppt_state_t st;
    ppt_state_t next_st;
    ppt_pkg::ppt_phase_t phase;
    logic strobe_last;
    logic cyc_done;
    logic start;
    logic start_write;
    logic slave_mode;
    logic busy;
    logic mux_on;

    assign slave_mode = ~st.port_mode[1];
    assign busy = (phase != ppt_pkg::PPT_IDLE);
    assign mux_on = (st.location_multiplex_select != ppt_pkg::MUX_SEPARATE);

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'h0) && (a <= ppt_pkg::OFS_MREAD);
    endfunction

    ppt_strobe_seq u_seq (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_start(start),
        .i_write(start_write),
        .i_mux_on(mux_on),
        .i_setup(st.strobe_setup_wait),
        .i_width(st.strobe_width_wait),
        .i_hold(st.strobe_hold_wait),
        .o_phase(phase),
        .o_strobe_last(strobe_last),
        .o_done(cyc_done)
    );

    // ------------------------------------------------------------
    // Bus handshakes and pins
    // ------------------------------------------------------------
    assign o_s_axi_awready = ~st.aw_got & ~st.bvalid;
    assign o_s_axi_wready = ~st.w_got & ~st.bvalid;
    assign o_s_axi_bvalid = st.bvalid;
    assign o_s_axi_bresp = st.bresp;
    assign o_s_axi_arready = ~st.rvalid;
    assign o_s_axi_rvalid = st.rvalid;
    assign o_s_axi_rresp = st.rresp;
    assign o_s_axi_rdata = st.rdata;
    assign o_host_rdata = st.host_rdata;

    assign o_chip_select_one_pin = st.chip_select_one_active;
    assign o_select_pin_function_enable = st.select_pin_function_enable;
    assign o_location_pin_function_enable = st.location_pin_function_enable;
    assign o_read_strobe = (phase == ppt_pkg::PPT_STROBE) & ~st.cyc_write;
    assign o_write_strobe = (phase == ppt_pkg::PPT_STROBE) & st.cyc_write;
    // Multiplexed address phase puts low location byte on data pins
    assign o_port_data_pins = (phase == ppt_pkg::PPT_ADDR) ? st.location[7:0] : st.mwdata;
    assign o_port_data_pins_oe = (phase == ppt_pkg::PPT_ADDR) | (busy & st.cyc_write);

    always_comb begin
        o_location_pins = st.location;
        if (mux_on) begin
            // Pad 0 becomes a latch strobe, pad 1 too when select bit 1 is set; held for the address phase
            o_location_pins[0] = (phase == ppt_pkg::PPT_ADDR);
            o_location_pins[1] = (phase == ppt_pkg::PPT_ADDR) & st.location_multiplex_select[1];
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] wa;
        logic [9:0] stepv;
        logic [31:0] rd;
        next_st = st;
        wa = st.aw_addr;
        stepv = 10'h0;
        rd = 32'h0;
        start = 1'b0;
        start_write = 1'b0;

        if (i_s_axi_awvalid && o_s_axi_awready) begin
            next_st.aw_got = 1'b1;
            next_st.aw_addr = i_s_axi_awaddr;
        end
        if (i_s_axi_wvalid && o_s_axi_wready) begin
            next_st.w_got = 1'b1;
            next_st.wdata = i_s_axi_wdata;
            next_st.wstrb = i_s_axi_wstrb;
        end
        if (st.bvalid && i_s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (st.rvalid && i_s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end

        // Last strobe cycle: capture read data; master cycle end: step location
        if (strobe_last && !st.cyc_write) begin
            next_st.mrdata = i_port_data_pins;
        end
        if (cyc_done && (st.step_mode == ppt_pkg::STEP_INC
                         || st.step_mode == ppt_pkg::STEP_DEC)) begin
            stepv = {st.chip_select_one_active, st.location[10:ppt_pkg::STEP_LO]};
            stepv = (st.step_mode == ppt_pkg::STEP_INC) ? stepv + 10'h1 : stepv - 10'h1;
            next_st.location[10:ppt_pkg::STEP_LO] = stepv[8:0];
            if (!st.select_pin_function_enable) begin
                next_st.chip_select_one_active = stepv[9];
            end
        end

        // Register write once address and data are both held
        if (st.aw_got && st.w_got) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = mapped(wa) ? ppt_pkg::RESP_OKAY : ppt_pkg::RESP_SLVERR;
            unique case (wa)
                ppt_pkg::OFS_MODE: begin
                    if (st.wstrb[0]) begin
                        next_st.strobe_hold_wait = st.wdata[ppt_pkg::HOLD_LSB +: 2];
                        next_st.strobe_width_wait = st.wdata[ppt_pkg::WIDTH_LSB +: 4];
                        next_st.strobe_setup_wait = st.wdata[ppt_pkg::SETUP_LSB +: 2];
                    end
                    if (st.wstrb[1]) begin
                        next_st.port_mode = st.wdata[ppt_pkg::PMODE_LSB +: 2];
                        next_st.step_mode = st.wdata[ppt_pkg::STEP_LSB +: 2];
                    end
                    if (st.wstrb[2]) begin
                        next_st.location_multiplex_select = st.wdata[ppt_pkg::MUX_LSB +: 2];
                    end
                end
                ppt_pkg::OFS_TARGET: begin
                    if (st.wstrb[0]) begin
                        next_st.location[7:0] = st.wdata[7:0];
                    end
                    if (st.wstrb[1]) begin
                        next_st.location[10:8] = st.wdata[10:8];
                        next_st.chip_select_one_active = st.wdata[ppt_pkg::CS1_BIT];
                    end
                end
                ppt_pkg::OFS_PIN_EN: begin
                    if (st.wstrb[0]) begin
                        next_st.location_pin_function_enable[7:0] = st.wdata[7:0];
                    end
                    if (st.wstrb[1]) begin
                        next_st.location_pin_function_enable[10:8] = st.wdata[10:8];
                        next_st.select_pin_function_enable = st.wdata[ppt_pkg::CS1_BIT];
                    end
                end
                ppt_pkg::OFS_STATUS: begin
                    // Only a written zero clears; a host event later this cycle still sets
                    if (st.wstrb[1] && !st.wdata[ppt_pkg::OVF_BIT]) begin
                        next_st.input_overflow = 1'b0;
                    end
                    if (st.wstrb[0] && !st.wdata[ppt_pkg::UNF_BIT]) begin
                        next_st.output_underflow = 1'b0;
                    end
                end
                ppt_pkg::OFS_OUT_BUF: begin
                    for (int i = 0; i < NUM_BUF; i++) begin
                        if (st.wstrb[i]) begin
                            next_st.out_buf[i] = st.wdata[8*i +: 8];
                            next_st.output_buffer_n_empty[i] = 1'b0;
                        end
                    end
                end
                ppt_pkg::OFS_MWRITE, ppt_pkg::OFS_MREAD: begin
                    // Ignored unless a master mode is idle
                    if (!slave_mode && !busy) begin
                        start = 1'b1;
                        start_write = (wa == ppt_pkg::OFS_MWRITE);
                        next_st.cyc_write = start_write;
                        if (start_write) begin
                            next_st.mwdata = st.wdata[7:0];
                        end
                    end
                end
                default: ;
            endcase
        end

        // Register read
        if (i_s_axi_arvalid && o_s_axi_arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = mapped(i_s_axi_araddr) ? ppt_pkg::RESP_OKAY : ppt_pkg::RESP_SLVERR;
            unique case (i_s_axi_araddr)
                ppt_pkg::OFS_MODE: begin
                    rd[ppt_pkg::HOLD_LSB +: 2] = st.strobe_hold_wait;
                    rd[ppt_pkg::WIDTH_LSB +: 4] = st.strobe_width_wait;
                    rd[ppt_pkg::SETUP_LSB +: 2] = st.strobe_setup_wait;
                    rd[ppt_pkg::PMODE_LSB +: 2] = st.port_mode;
                    rd[ppt_pkg::STEP_LSB +: 2] = st.step_mode;
                    rd[ppt_pkg::BUSY_BIT] = busy;
                    rd[ppt_pkg::MUX_LSB +: 2] = st.location_multiplex_select;
                end
                ppt_pkg::OFS_TARGET: begin
                    rd[10:0] = st.location;
                    rd[ppt_pkg::CS1_BIT] = st.chip_select_one_active;
                end
                ppt_pkg::OFS_PIN_EN: begin
                    rd[10:0] = st.location_pin_function_enable;
                    rd[ppt_pkg::CS1_BIT] = st.select_pin_function_enable;
                end
                ppt_pkg::OFS_STATUS: begin
                    rd[ppt_pkg::ALL_FULL_BIT] = &st.input_buffer_n_full;
                    rd[ppt_pkg::OVF_BIT] = st.input_overflow;
                    rd[ppt_pkg::IN_FULL_LSB +: 4] = st.input_buffer_n_full;
                    rd[ppt_pkg::ALL_EMPTY_BIT] = &st.output_buffer_n_empty;
                    rd[ppt_pkg::UNF_BIT] = st.output_underflow;
                    rd[ppt_pkg::OUT_EMPTY_LSB +: 4] = st.output_buffer_n_empty;
                end
                ppt_pkg::OFS_OUT_BUF: rd = st.out_buf;
                ppt_pkg::OFS_IN_BUF: begin
                    rd = st.in_buf;
                    next_st.input_buffer_n_full = '0;
                end
                ppt_pkg::OFS_MWRITE: rd[7:0] = st.mwdata;
                ppt_pkg::OFS_MREAD: rd[7:0] = st.mrdata;
                default: rd = 32'h0;
            endcase
            next_st.rdata = rd;
        end

        // Host side, slave modes only; sets win over software clears
        if (slave_mode && i_host_wr) begin
            if (st.input_buffer_n_full[i_host_sel]) begin
                next_st.input_overflow = 1'b1;
            end else begin
                next_st.in_buf[i_host_sel] = i_host_wdata;
                next_st.input_buffer_n_full[i_host_sel] = 1'b1;
            end
        end
        if (slave_mode && i_host_rd) begin
            if (st.output_buffer_n_empty[i_host_sel]) begin
                next_st.output_underflow = 1'b1;
            end else begin
                next_st.host_rdata = st.out_buf[i_host_sel];
                next_st.output_buffer_n_empty[i_host_sel] = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
            st.strobe_hold_wait <= ppt_pkg::RST_WAIT;
            st.strobe_setup_wait <= ppt_pkg::RST_WAIT;
            st.input_buffer_n_full <= ppt_pkg::RST_IN_FULL;
            st.output_buffer_n_empty <= ppt_pkg::RST_OUT_EMPTY;
        end else begin
            st <= next_st;
        end
    end
endmodule

// ===== sim/ppt_periph.sv
// Peripheral model at the port's data pins
module ppt_periph #(
    parameter logic [7:0] RD_BYTE = 8'hA5
) (
    input wire logic i_clk,
    input wire logic i_read_strobe,
    output logic [7:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] idle = 8'h00;
    // Undriven bus changes every cycle so a late sample never matches
    always @(posedge i_clk) begin
        idle <= ~idle;
    end
    assign o_data = i_read_strobe ? RD_BYTE : idle;
endmodule

// ===== sim/ppt_port_chk.sv
// Checker of bus handshake and strobe phases at the port's pins
module ppt_port_chk (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_s_axi_bready,
    input wire logic i_s_axi_rready,
    input wire logic o_s_axi_awready,
    input wire logic o_s_axi_arready,
    input wire logic o_s_axi_bvalid,
    input wire logic o_s_axi_rvalid,
    input wire logic o_port_data_pins_oe,
    input wire logic o_read_strobe,
    input wire logic o_write_strobe
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_wr_end;
        $fell(o_write_strobe);
    endsequence
    a_b_stands: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid)
        else $error("write response dropped early");
    a_r_stands: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid)
        else $error("read response dropped early");
    a_aw_refused: assert property (o_s_axi_bvalid |-> !o_s_axi_awready)
        else $error("write address taken during response");
    a_ar_refused: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
        else $error("read address taken during response");
    a_strobe_excl: assert property (!(o_write_strobe && o_read_strobe))
        else $error("both strobes active");
    a_write_drive: assert property (o_write_strobe |-> o_port_data_pins_oe)
        else $error("write data not driven in strobe");
    a_write_hold: assert property (s_wr_end |-> o_port_data_pins_oe)
        else $error("write data released at strobe end");
    a_read_free: assert property (o_read_strobe |-> !o_port_data_pins_oe)
        else $error("data pins driven during read");
endmodule
bind ppt_port ppt_port_chk u_chk (.*);

// ===== sim/ppt_port_tb_top.sv
// Self-checking bench of the parallel port
module ppt_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk, i_rst, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid;
    logic i_s_axi_rready, i_host_wr, i_host_rd, o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
    logic o_s_axi_arready, o_s_axi_rvalid, o_port_data_pins_oe, o_chip_select_one_pin;
    logic o_select_pin_function_enable, o_read_strobe, o_write_strobe;
    logic [7:0] i_s_axi_awaddr, i_s_axi_araddr, i_host_wdata, o_host_rdata;
    logic [7:0] i_port_data_pins, o_port_data_pins, pd;
    logic [31:0] i_s_axi_wdata, o_s_axi_rdata, rd;
    logic [1:0] o_s_axi_bresp, o_s_axi_rresp, i_host_sel, rs;
    logic [3:0] i_s_axi_wstrb;
    logic [10:0] o_location_pins, o_location_pin_function_enable;
    int fail_count, checks, n, s, w, h;
    int tm[6] = '{32'h24B, 32'h23C, 32'h102C3, 32'hA00, 32'hA00, 32'h1200};
    int tv[6] = '{32'h123, 32'h4555, 32'h7FF, 32'h47FF, 32'h7FF, 32'h0};
    int te[6] = '{32'h123, 32'h4555, 32'h7FF, 32'h4003, 32'h4003, 32'h47FC};
    int es[6] = '{2, 1, 2, 1, 1, 1};
    int ew[6] = '{3, 16, 1, 1, 1, 1};
    int eh[6] = '{4, 1, 1, 1, 1, 1};
    ppt_port uut (.*);
    ppt_periph u_periph (.i_clk(i_clk), .i_read_strobe(o_read_strobe), .o_data(i_port_data_pins));
    // ----
    // Tasks
    // ----
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic guard(input int k);
        if (k >= 40) begin
            fail_count++;
            test_done();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge i_clk);
        k = 0;
        i_s_axi_awaddr <= a;
        i_s_axi_wdata <= d;
        i_s_axi_awvalid <= 1'b1;
        i_s_axi_wvalid <= 1'b1;
        i_s_axi_bready <= 1'b1;
        do begin
            @(posedge i_clk);
            if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
            if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
            k++;
        end while (o_s_axi_bvalid !== 1'b1 && k < 40);
        i_s_axi_bready <= 1'b0;
        guard(k);
    endtask
    task automatic rr(input logic [7:0] a);
        int k;
        @(posedge i_clk);
        k = 0;
        i_s_axi_araddr <= a;
        i_s_axi_arvalid <= 1'b1;
        i_s_axi_rready <= 1'b1;
        do begin
            @(posedge i_clk);
            if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
            k++;
        end while (o_s_axi_rvalid !== 1'b1 && k < 40);
        rd = o_s_axi_rdata;
        rs = o_s_axi_rresp;
        i_s_axi_rready <= 1'b0;
        guard(k);
    endtask
    task automatic host(input logic wrt, input logic [1:0] sel, input logic [7:0] d);
        @(posedge i_clk);
        i_host_wr <= wrt;
        i_host_rd <= !wrt;
        i_host_sel <= sel;
        i_host_wdata <= d;
        @(posedge i_clk);
        i_host_wr <= 1'b0;
        i_host_rd <= 1'b0;
    endtask
    initial begin
        i_clk = 0;
        forever #5 i_clk = ~i_clk;
    end
    // ----
    // Main sequence
    // ----
    initial begin
        {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready} = '0;
        {i_host_wr, i_host_rd, i_host_sel, i_host_wdata, i_s_axi_awaddr, i_s_axi_araddr} = '0;
        i_s_axi_wdata = '0;
        i_s_axi_wstrb = 4'hF;
        i_rst = 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        rr(8'h0C);
        cmp(rd, 32'h8F);
        rr(8'h04);
        cmp(rd, 32'h0);
        rr(8'h40);
        cmp({rd[29:0], rs}, {30'h0, ppt_pkg::RESP_SLVERR});
        for (int b = 0; b < 4; b++) begin
            host(1'b1, b[1:0], 8'h10 + 8'(b));
            rr(8'h0C);
            cmp(rd, ((b == 3) ? 32'h8000 : 32'h0) | (((2 << b) - 1) << 8) | 32'h8F);
        end
        // Host ignores the full status here on purpose
        host(1'b1, 2'h0, 8'hEE);
        rr(8'h0C);
        cmp(rd, 32'hCF8F);
        rr(8'h14);
        cmp(rd, 32'h13121110);
        rr(8'h0C);
        cmp(rd, 32'h408F);
        wr(8'h0C, 32'h0);
        host(1'b0, 2'h1, 8'h00);
        rr(8'h0C);
        cmp(rd, 32'h00CF);
        wr(8'h10, 32'h44332211);
        host(1'b0, 2'h2, 8'h00);
        @(negedge i_clk);
        cmp(o_host_rdata, 32'h33);
        rr(8'h0C);
        cmp(rd, 32'h0044);
        for (int t = 0; t < 6; t++) begin
            wr(8'h04, tv[t]);
            wr(8'h08, tv[t]);
            cmp({o_select_pin_function_enable, o_location_pin_function_enable},
                {tv[t][14], tv[t][10:0]});
            wr(8'h00, tm[t]);
            {s, w, h, pd} = '0;
            fork
                wr(8'h18, 32'h5A);
                repeat (40) begin
                    @(negedge i_clk);
                    if (o_write_strobe === 1'b1) {w, pd} = {w + 1, o_port_data_pins};
                    else if (o_port_data_pins_oe === 1'b1 && w > 0) h++;
                    else if (o_port_data_pins_oe === 1'b1) s++;
                end
            join
            cmp({8'(s), 8'(w), 8'(h)}, {8'(es[t]), 8'(ew[t]), 8'(eh[t])});
            cmp(pd, 32'h5A);
            rr(8'h04);
            cmp(rd, te[t]);
            cmp(o_chip_select_one_pin, te[t][14]);
            cmp(o_location_pins[10:2], te[t][10:2]);
        end
        host(1'b1, 2'h0, 8'h77);
        rr(8'h0C);
        cmp(rd, 32'h0044);
        wr(8'h1C, 32'h0);
        n = 0;
        do begin
            rr(8'h00);
            n++;
        end while (rd[ppt_pkg::BUSY_BIT] !== 1'b0 && n < 40);
        guard(n);
        rr(8'h1C);
        cmp(rd, 32'hA5);
        test_done();
    end
endmodule
